// ===== hw/lds_pkg.sv
package lds_pkg;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_W     = 16;
  localparam int ADDR_W      = 7;
  localparam int DATA_W      = 8;
  localparam int RW_BIT      = 15;
  localparam int ADDR_MSB    = 14;
  localparam int ADDR_LSB    = 8;
  localparam int DATA_MSB    = 7;
  localparam int DATA_LSB    = 0;
  localparam int CMD_LSB     = 8;
  localparam logic RW_WRITE  = 1'b0;
  localparam logic RW_READ   = 1'b1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [FRAME_W-1:0] FRAME_RST = 16'h0000;
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 7'h00;
  localparam logic [DATA_W-1:0]  DATA_RST  = 8'h00;

  // ----------------------------------------------------------------
  // core-side sequencing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LDS_IDLE,
    LDS_READ,
    LDS_CAPTURE
  } lds_state_e;
endpackage

// ===== hw/lds_spi_slave.sv
`timescale 1ns/1ps
// Behaviour
// R1 - shifting happens only while select low
// R2 - host keeps input stable at rising edge
// R3 - output stable at each rising edge
// R4 - output pin always driven in output mode
// R5 - clock and data ignored while deselected
// R6 - sixteen-bit frame, msb first, command then data
// R7 - top bit zero writes low byte
// R8 - top bit one reads seven-bit address
// R9 - read frame low byte is discarded
// R10 - read data loaded into low byte
// R11 - host fetches read data next frame
// R12 - input reappears at output 15.5 clocks later
// R13 - last sixteen bits latched at release
// R14 - host lowers clock before select falls
// R15 - host may release select clock high or low
// R16 - cascaded devices need sixteen clocks each
// R17 - config bit seven selects pwm clock input
// R18 - power-up pin function set per variant
// R19 - no readback while pin is clock input
// R20 - write applied in one step at release
module lds_spi_slave #(
  parameter logic PIN_CLOCK_DEFAULT = 1'b0,
  parameter int   SYNC_STAGES       = 2
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          sclk,
  input  wire logic                          cs_n,
  input  wire logic                          din,
  input  wire logic                          shared_output_clock_pin_i,
  output logic                               shared_output_clock_pin_o,
  output logic                               shared_output_clock_pin_oe,
  input  wire logic                          cfg_pin_clock_sel,
  output logic                               reg_wr,
  output logic                               reg_rd,
  output logic [lds_pkg::ADDR_W-1:0]         reg_addr,
  output logic [lds_pkg::DATA_W-1:0]         reg_wdata,
  input  wire logic [lds_pkg::DATA_W-1:0]    reg_rdata,
  output logic                               pwm_clock_input,
  output logic                               pin_clock_mode
);
  import lds_pkg::*;

  // ----------------------------------------------------------------
  // link side: shift register on the serial clock
  // ----------------------------------------------------------------
  logic [FRAME_W-1:0] shift_reg;
  logic [FRAME_W-1:0] shift_next;
  logic [FRAME_W-1:0] shift_src;
  logic               first_reg;
  logic               ack_tgl_reg;
  logic               dout_reg;
  logic               ld_tgl_reg;
  logic [DATA_W-1:0]  ld_byte_reg;
  logic               ld_pend;

  // the byte and its toggle are written by the core long before the next
  // frame starts and hold still while the link samples them; this relies on
  // select staying high for a few core clocks between frames
  assign ld_pend = ld_tgl_reg ^ ack_tgl_reg;

  always_comb begin
    shift_src = shift_reg;
    if (first_reg && ld_pend) begin
      shift_src = {shift_reg[FRAME_W-1:CMD_LSB], ld_byte_reg};  // [R10]
    end
    shift_next = {shift_src[FRAME_W-2:0], din};                // [R6] [R13]
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      shift_reg <= FRAME_RST;
    end else if (!cs_n) begin                                   // [R1] [R5]
      shift_reg <= shift_next;
    end
  end

  // marks the first rising edge of a frame; select high sets it at once
  // since the serial clock may never tick between frames
  always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
    if (rst) begin
      first_reg <= 1'b1;
    end else if (cs_n) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      ack_tgl_reg <= 1'b0;
    end else if (!cs_n && first_reg) begin
      ack_tgl_reg <= ld_tgl_reg;
    end
  end

  // falling-edge update gives the half cycle and a value settled by the rise
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      dout_reg <= 1'b0;
    end else if (!cs_n) begin                                   // [R5]
      dout_reg <= shift_reg[FRAME_W-1];                         // [R12] [R3] [R16]
    end
  end

  assign shared_output_clock_pin_o = dout_reg;

  // ----------------------------------------------------------------
  // core side: select synchroniser and release detect
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] cs_sync_reg;
  logic                   cs_last_reg;
  logic                   cs_rise;

  // both idle high so that leaving reset never looks like a release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_sync_reg <= '1;
    end else begin
      cs_sync_reg <= {cs_sync_reg[SYNC_STAGES-2:0], cs_n};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_last_reg <= 1'b1;
    end else begin
      cs_last_reg <= cs_sync_reg[SYNC_STAGES-1];
    end
  end

  assign cs_rise = cs_sync_reg[SYNC_STAGES-1] && !cs_last_reg;

  // ----------------------------------------------------------------
  // pin function
  // ----------------------------------------------------------------
  logic mode_reg;
  logic oe_reg;

  // the pin function follows the config level every clock; no strobe needed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= PIN_CLOCK_DEFAULT;                            // [R18]
    end else begin
      mode_reg <= cfg_pin_clock_sel;                            // [R17]
    end
  end

  // in output mode the pin is never released, even while deselected
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_reg <= !PIN_CLOCK_DEFAULT;
    end else begin
      oe_reg <= !cfg_pin_clock_sel;                             // [R4]
    end
  end

  assign shared_output_clock_pin_oe = oe_reg;
  assign pin_clock_mode             = mode_reg;

  logic [SYNC_STAGES-1:0] pin_sync_reg;
  logic                   pwm_clk_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_sync_reg <= '0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[SYNC_STAGES-2:0], shared_output_clock_pin_i};
    end
  end

  // gated by the mode so our own data bits leak out as a clock only for SYNC_STAGES clocks after a switch into clock mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_clk_reg <= 1'b0;
    end else begin
      pwm_clk_reg <= mode_reg & pin_sync_reg[SYNC_STAGES-1];    // [R17]
    end
  end

  assign pwm_clock_input = pwm_clk_reg;

  // ----------------------------------------------------------------
  // core side: frame decode
  // ----------------------------------------------------------------
  lds_state_e        state_reg;
  logic              take_frame;
  logic              frame_is_write;
  logic              frame_is_read;
  logic              capture_now;
  logic              wr_reg;
  logic              rd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;

  // the shift register is quiet once select is high, so it is read whole;
  // a release during a read sequence is not taken, so select must stay
  // high long enough between frames for the sequence to finish
  assign take_frame     = (state_reg == LDS_IDLE) && cs_rise;
  assign frame_is_write = take_frame && (shift_reg[RW_BIT] == RW_WRITE);   // [R7]
  // a read in clock-pin mode is dropped: no pin could carry the byte out
  assign frame_is_read  = take_frame && (shift_reg[RW_BIT] == RW_READ)
                          && !mode_reg;                                   // [R8] [R19]
  assign capture_now    = (state_reg == LDS_CAPTURE);

  // ----------------------------------------------------------------
  // core side: read sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= LDS_IDLE;
    end else begin
      case (state_reg)
        LDS_IDLE: begin
          if (frame_is_read) begin
            state_reg <= LDS_READ;
          end
        end
        LDS_READ: begin
          state_reg <= LDS_CAPTURE;
        end
        LDS_CAPTURE: begin
          state_reg <= LDS_IDLE;
        end
        default: begin
          state_reg <= LDS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // core side: register strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg <= 1'b0;
    end else begin
      wr_reg <= frame_is_write;                                 // [R20]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_reg <= 1'b0;
    end else begin
      rd_reg <= frame_is_read;                                  // [R8]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg <= ADDR_RST;
    end else if (take_frame) begin
      addr_reg <= shift_reg[ADDR_MSB:ADDR_LSB];                 // [R13]
    end
  end

  // left alone on reads: the dummy byte of a read means nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdata_reg <= DATA_RST;
    end else if (frame_is_write) begin
      wdata_reg <= shift_reg[DATA_MSB:DATA_LSB];                // [R9]
    end
  end

  // ----------------------------------------------------------------
  // core side: read byte hand-over
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ld_byte_reg <= DATA_RST;
    end else if (capture_now) begin
      ld_byte_reg <= reg_rdata;                                 // [R10]
    end
  end

  // the toggle tells the link side that a fresh byte waits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ld_tgl_reg <= 1'b0;
    end else if (capture_now) begin
      ld_tgl_reg <= !ld_tgl_reg;
    end
  end

  // ----------------------------------------------------------------
  // core side: outputs
  // ----------------------------------------------------------------
  assign reg_wr    = wr_reg;
  assign reg_rd    = rd_reg;
  assign reg_addr  = addr_reg;
  assign reg_wdata = wdata_reg;
endmodule

// ===== sim/lds_host_model.sv
`timescale 1ns/1ps
module lds_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  // ----
  // serial host
  // ----
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // msb first, sample on rise, clock low again before release
  task automatic xfer(input logic [31:0] tx, input int n, input logic sel, output logic [31:0] rx);
    rx = '0;
    cs_n = !sel;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      din = tx[i];
      #80 sclk = 1'b1;
      rx = {rx[30:0], dout};
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    din = !din; // released line shows no stale bit
  endtask
endmodule

// ===== sim/lds_spi_slave_checker.sv
`timescale 1ns/1ps
module lds_spi_slave_checker import lds_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic cfg_pin_clock_sel,
  input wire logic shared_output_clock_pin_o,
  input wire logic shared_output_clock_pin_oe,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic pwm_clock_input,
  input wire logic pin_clock_mode
);
  // ----
  // port checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_pin_out; (!cfg_pin_clock_sel)[*2] |-> shared_output_clock_pin_oe && !pin_clock_mode; endproperty
  property p_pin_clk; cfg_pin_clock_sel[*2] |-> !shared_output_clock_pin_oe && pin_clock_mode; endproperty
  property p_wr_one; reg_wr |=> !reg_wr; endproperty
  property p_excl; !(reg_wr && reg_rd); endproperty
  property p_sel_idle; (reg_wr || reg_rd) |-> cs_n && $past(cs_n, 2); endproperty
  property p_no_rd; reg_rd |-> !pin_clock_mode; endproperty
  property p_pwm_off; (!pin_clock_mode)[*4] |-> !pwm_clock_input; endproperty
  // sampled on clk, so sclk is still low when the fall-launched bit lands
  property p_dout_fall; $changed(shared_output_clock_pin_o) |-> !sclk; endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin not output");
  a_pin_clk: assert property (p_pin_clk) else $error("pin not input");
  a_wr_one: assert property (p_wr_one) else $error("write pulse long");
  a_excl: assert property (p_excl) else $error("read and write");
  a_sel_idle: assert property (p_sel_idle) else $error("early strobe");
  a_no_rd: assert property (p_no_rd) else $error("read in clock mode");
  a_pwm_off: assert property (p_pwm_off) else $error("pwm clock leak");
  a_dout_fall: assert property (p_dout_fall) else $error("dout moved high");
  c_wr: cover property (reg_wr);
  c_rd: cover property (reg_rd);
  c_mode: cover property (pin_clock_mode);
endmodule
bind lds_spi_slave lds_spi_slave_checker lds_spi_slave_checker_inst (.*);

// ===== sim/lds_spi_slave_tb_top.sv
`timescale 1ns/1ps
module lds_spi_slave_tb_top;
  import lds_pkg::*;
  logic              clk, rst, cfg, osc;
  logic [DATA_W-1:0] rdata;
  logic [31:0]       rx;
  wire               sclk, cs_n, din, pin_i, pin_o, pin_oe, wr, rd, pwm, mode;
  wire [ADDR_W-1:0]  addr;
  wire [DATA_W-1:0]  wdata;
  int                bad_count, n_compared, wr_cnt, rd_cnt;
  assign pin_i = pin_oe ? pin_o : osc;
  lds_spi_slave lds_spi_slave_inst (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .shared_output_clock_pin_i(pin_i), .shared_output_clock_pin_o(pin_o),
    .shared_output_clock_pin_oe(pin_oe), .cfg_pin_clock_sel(cfg), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .pwm_clock_input(pwm),
    .pin_clock_mode(mode));
  lds_host_model lds_host_model_inst (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(pin_i));
  // ----
  // helpers
  // ----
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    wr_cnt += wr;
    rd_cnt += rd;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // select must stay high at least 8 clk between frames
  task automatic send(input logic [31:0] tx, input int n, input logic sel);
    lds_host_model_inst.xfer(tx, n, sel, rx);
    repeat (12) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_write_read;
    send(32'h12a5, 16, 1'b1);
    check({1'b0, addr, wdata}, 16'h12a5);
    send(32'h91ff, 16, 1'b1);
    check({1'b1, addr, wdata}, 16'h91a5);
    send(32'h9100, 16, 1'b1);
    check(rx[15:0], 16'h913c);
    check(16'(rd_cnt), 16'h0002);
  endtask
  task automatic t_odd_counts;
    send(32'hf125a, 20, 1'b1);
    check({1'b0, addr, wdata}, 16'h125a);
    send(32'h77, 8, 1'b1);
    check({1'b0, addr, wdata}, 16'h5a77);
    send(32'hffff, 16, 1'b0);
    check(16'(wr_cnt), 16'h0003);
  endtask
  task automatic t_clock_pin;
    cfg <= 1'b1;
    osc <= 1'b1;
    repeat (8) @(posedge clk);
    check({mode, pin_oe, pwm}, 16'h0005);
    send(32'h91ff, 16, 1'b1);
    check(16'(rd_cnt), 16'h0002);
    cfg <= 1'b0;
    repeat (8) @(posedge clk);
    check({mode, pin_oe, pwm}, 16'h0002);
  endtask
  initial begin
    rst = 1'b1;
    cfg = 1'b0;
    osc = 1'b0;
    rdata = 8'h3c;
    repeat (10) @(posedge clk);
    check({mode, pin_oe}, 16'h0001);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_write_read();
    t_odd_counts();
    t_clock_pin();
    wrap_up();
  end
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule
